// ===== hw/brd_pkg.sv
// brd_pkg: constants for the per-channel bit-rate divider.
// assumes a single 25 MHz system clock and an asynchronous active-low reset.
`default_nettype none
package brd_pkg;
  // field positions inside the channel configuration bytes
  localparam int CFG1_OVERSAMPLE_BIT = 3;
  localparam int CFG2_BYPASS_BIT = 5;
  localparam int CFG2_HIGH_MSB = 7;
  localparam int CFG2_HIGH_LSB = 6;
  localparam int CFG3_RECEIVE_ADDRESS_FLAG_BIT = 4;
  localparam int CFG4_ENHANCED_BIT = 6;
  // general port lanes used to program the external synthesizer
  localparam int PORT_SYNTH_DATA_BIT = 0;
  localparam int PORT_SYNTH_CLK_BIT = 1;
  // divider geometry: (63+1)*2^15 needs 22 bits
  localparam int DIV_W = 22;
  localparam int SUB_W = 4;
  localparam logic [SUB_W-1:0] SUB_LAST = 4'hf; // divide by 16
  localparam logic [DIV_W-1:0] DIV_ONE = 22'h000001;
  localparam logic [DIV_W-1:0] DIV_RESET = 22'h000002; // standard N=0
  // oscillator limits kept by software (kHz)
  localparam int OSC_MIN_KHZ = 391;
  localparam int OSC_MAX_KHZ = 33000;
  localparam int OSC_MAX_MASTER_KHZ = 10000;
endpackage
`default_nettype wire

// ===== hw/brd_baud_rate_divider.sv
// brd_baud_rate_divider: one channel's bit-rate generator plus line-driver
// and synthesizer-port glue. assumes the oscillator and external clock are
// asynchronous to clk_sys and slower than half of it.
//
// Overview of operation
// - standard mode divides the input clock by (count plus one) times two.
// - ten-bit count is config-two bits 7:6 above the low divider byte.
// - enhanced mode divides by (n+1) times two to the power m.
// - divider bypass in config-two bit 5 forces a divisor of one.
// - enhanced formula only when config-four bit 6 set and bypass clear.
// - oversample bit, config-one bit 3, adds a further divide by 16.
// - standard count with low six bits zero acts as count zero.
// - asynchronous mode 7b clocks the divider from the oscillator input.
// - on a shared multidrop pair only one station drives at a time.
// - in multidrop mode the line receiver stays enabled permanently.
// - general port bit 0 is synthesizer data, bit 1 its clock.
// - clock-recovery modes divide the divider output by 16 more.
`default_nettype none
module brd_baud_rate_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // clock sources from pins
  input wire logic oscillator_input,
  input wire logic ext_clock_in,
  // configuration bytes
  input wire logic [7:0] channel_config_one,
  input wire logic [7:0] channel_config_two,
  input wire logic [7:0] channel_config_four,
  input wire logic [7:0] divider_low_count,
  // clock mode selection
  input wire logic mode_7b,
  input wire logic clock_recovery_loop,
  // general port and line control
  input wire logic [7:0] general_port,
  input wire logic multidrop_mode,
  input wire logic transmit_request,
  input wire logic receive_enable_req,
  // outputs
  output logic bit_tick_q,
  output logic [brd_pkg::DIV_W-1:0] divisor_q,
  output logic synth_data_q,
  output logic synth_clk_q,
  output logic line_drive_en_n_q,
  output logic line_receive_en_q
);

  typedef struct packed {
    logic [1:0] osc_sync;
    logic [1:0] ext_sync;
    logic src_prev;
    logic [brd_pkg::DIV_W-1:0] cnt;
    logic [brd_pkg::SUB_W-1:0] sub;
    logic [26:0] shadow;
    logic tick;
    logic [brd_pkg::DIV_W-1:0] divisor;
    logic synth_data;
    logic synth_clk;
    logic drive_en_n;
    logic rx_en;
  } brd_state_t;

  brd_state_t s_q;
  brd_state_t s_d;

  // divisor decode, shared by the counter and the status output
  function automatic logic [brd_pkg::DIV_W-1:0] calc_divisor(
    input logic [7:0] cfg2,
    input logic [7:0] cfg4,
    input logic [7:0] low
  );
    logic [9:0] n_full;
    logic [6:0] n_small;
    logic [3:0] m_exp;
    n_full = {cfg2[brd_pkg::CFG2_HIGH_MSB:brd_pkg::CFG2_HIGH_LSB], low};
    n_small = {1'b0, low[5:0]} + 7'h01;
    m_exp = {cfg2[brd_pkg::CFG2_HIGH_MSB:brd_pkg::CFG2_HIGH_LSB], low[7:6]};
    if (low[5:0] == 6'h00) begin
      n_full = 10'h000;
    end
    if (cfg2[brd_pkg::CFG2_BYPASS_BIT]) begin
      calc_divisor = brd_pkg::DIV_ONE;
    end else if (cfg4[brd_pkg::CFG4_ENHANCED_BIT]) begin
      calc_divisor = {15'h0000, n_small} << m_exp;
    end else begin
      calc_divisor = {11'h000, ({1'b0, n_full} + 11'h001)} << 1;
    end
  endfunction

  logic [26:0] cfg_now;
  logic [brd_pkg::DIV_W-1:0] div_now;
  logic src_level;
  logic src_edge;
  logic use_sixteen;
  logic pre_tick;

  // next-state logic for the whole channel
  always_comb begin
    s_d = s_q;
    cfg_now = {channel_config_one[brd_pkg::CFG1_OVERSAMPLE_BIT], channel_config_two,
               channel_config_four[brd_pkg::CFG4_ENHANCED_BIT], divider_low_count,
               mode_7b, clock_recovery_loop, 7'h00};
    div_now = calc_divisor(channel_config_two, channel_config_four, divider_low_count);
    // pins pass two flops before anything looks at them
    s_d.osc_sync = {s_q.osc_sync[0], oscillator_input};
    s_d.ext_sync = {s_q.ext_sync[0], ext_clock_in};
    src_level = mode_7b ? s_q.osc_sync[1] : s_q.ext_sync[1];
    s_d.src_prev = src_level;
    src_edge = src_level & ~s_q.src_prev;
    use_sixteen = channel_config_one[brd_pkg::CFG1_OVERSAMPLE_BIT]
                  | clock_recovery_loop;
    pre_tick = 1'b0;
    s_d.tick = 1'b0;
    s_d.divisor = div_now;
    s_d.shadow = cfg_now;
    if (cfg_now != s_q.shadow) begin
      // restart so a half-old period never escapes after a reprogram
      s_d.cnt = '0;
      s_d.sub = '0;
    end else if (src_edge) begin
      if (s_q.cnt >= div_now - brd_pkg::DIV_ONE) begin
        s_d.cnt = '0;
        pre_tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + brd_pkg::DIV_ONE;
      end
    end
    // optional divide by 16 after the main divider
    if (pre_tick) begin
      if (!use_sixteen) begin
        s_d.tick = 1'b1;
        s_d.sub = '0;
      end else if (s_q.sub == brd_pkg::SUB_LAST) begin
        s_d.tick = 1'b1;
        s_d.sub = '0;
      end else begin
        s_d.sub = s_q.sub + 4'h1;
      end
    end
    // synthesizer serial lines copied from the general port
    s_d.synth_data = general_port[brd_pkg::PORT_SYNTH_DATA_BIT];
    s_d.synth_clk = general_port[brd_pkg::PORT_SYNTH_CLK_BIT];
    // a multidrop station drives only while it has something to send
    s_d.drive_en_n = multidrop_mode ? ~transmit_request : 1'b0;
    s_d.rx_en = multidrop_mode ? 1'b1 : receive_enable_req;
  end

  // single state register; reset puts the standard N=0 divisor in place
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.divisor <= brd_pkg::DIV_RESET;
      s_q.drive_en_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_tick_q = s_q.tick;
  assign divisor_q = s_q.divisor;
  assign synth_data_q = s_q.synth_data;
  assign synth_clk_q = s_q.synth_clk;
  assign line_drive_en_n_q = s_q.drive_en_n;
  assign line_receive_en_q = s_q.rx_en;

  // checks on the divisor decode, the tick pacing, the line enables and the synthesizer lanes
  a_bypass_div_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    channel_config_two[brd_pkg::CFG2_BYPASS_BIT] |=> divisor_q == brd_pkg::DIV_ONE)
    else $error("bypass did not give divisor one");
  a_std_formula: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!channel_config_two[5] && !channel_config_four[6] && divider_low_count[5:0] != 6'h00)
    |=> divisor_q == {11'h000, {1'b0, $past(channel_config_two[7:6]),
        $past(divider_low_count)} + 11'h001} * 22'h000002)
    else $error("standard divisor wrong");
  a_std_glitch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!channel_config_two[5] && !channel_config_four[6] && divider_low_count[5:0] == 6'h00)
    |=> divisor_q == brd_pkg::DIV_RESET)
    else $error("masked count not treated as zero");
  a_enh_formula: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!channel_config_two[5] && channel_config_four[6] && divider_low_count == 8'h01
     && channel_config_two[7:6] == 2'b00) |=> divisor_q == 22'h000002)
    else $error("enhanced divisor wrong");
  a_enh_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    (channel_config_two[5] && channel_config_four[6]) |=> divisor_q == brd_pkg::DIV_ONE)
    else $error("enhanced applied under bypass");
  a_tick_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cfg_now != s_q.shadow) |=> (s_q.cnt == '0 && !bit_tick_q))
    else $error("divider did not restart on reprogram");
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bit_tick_q && use_sixteen && $stable(cfg_now)) |=> !bit_tick_q [*2])
    else $error("oversampled ticks too close");
  a_bypass_fast: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_edge && !use_sixteen && s_q.divisor == brd_pkg::DIV_ONE && cfg_now == s_q.shadow
     && div_now == brd_pkg::DIV_ONE) |=> bit_tick_q)
    else $error("bypass edge gave no tick");
  a_rx_always_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    multidrop_mode |=> line_receive_en_q)
    else $error("receiver dropped in multidrop");
  a_drive_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    (multidrop_mode && !transmit_request) |=> line_drive_en_n_q)
    else $error("idle station still drives");
  a_synth_lanes: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> (synth_data_q == $past(general_port[0]) && synth_clk_q == $past(general_port[1])))
    else $error("synthesizer lanes swapped");

  c_tick_plain: cover property (@(posedge clk_sys) disable iff (!nrst)
    bit_tick_q && !use_sixteen);
  c_tick_sixteen: cover property (@(posedge clk_sys) disable iff (!nrst)
    bit_tick_q && use_sixteen);
  c_reprogram: cover property (@(posedge clk_sys) disable iff (!nrst) cfg_now != s_q.shadow);
  c_multidrop_tx: cover property (@(posedge clk_sys) disable iff (!nrst)
    multidrop_mode && !line_drive_en_n_q);

endmodule
`default_nettype wire

// ===== test/brd_far_side.sv
// brd_far_side: the clock synthesizer beside one channel, as its far side.
// assumes a 40 ns bench clock; its clocks change clear of that clock's edges.
`default_nettype none
module brd_far_side (
  // clock sources
  output logic osc_out,
  output logic ext_out,
  // programming port
  input wire logic prog_data,
  input wire logic prog_clk,
  output logic [7:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // oscillator at 6.25 MHz: inside the legal range and under half of clk_sys
  initial begin
    osc_out = 1'b0;
    #7;
    forever #80 osc_out = ~osc_out;
  end
  // second pin clock at 2.5 MHz, a different rate so that the source select shows;
  // oscillator over it is 2.5 and it over oscillator 0.4, inside both ratio limits
  initial begin
    ext_out = 1'b0;
    #7;
    forever #200 ext_out = ~ext_out;
  end
  // word shifts in msb first, one bit on each rising port clock; the unknown
  // start value is gone after eight shifts, so no second driver is needed
  always @(posedge prog_clk) prog_word <= {prog_word[6:0], prog_data};
endmodule
`default_nettype wire

// ===== test/test_baud_rate_divider.sv
// test_baud_rate_divider: table of divider settings, then reset, line and port cases.
// assumes brd_far_side supplies both clock sources and models the synthesizer.
`default_nettype none
module test_baud_rate_divider;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] c1, c2, c4, low; logic [1:0] mode; logic [21:0] div; int per;}
    brd_row_t;
  logic clk_sys, nrst, osc, ext, tick, sd, sc, drv_n, rx, md, tr, re;
  logic [7:0] c1, c2, c4, low, gp, word, pat;
  logic [1:0] mode;
  logic [21:0] div;
  int miscompares, checked, n;
  // mode is {oscillator select, clock recovery}; per is cycles between ticks
  brd_row_t rows[10] = '{
    '{8'h00, 8'h00, 8'h00, 8'h01, 2'h2, 22'h000004, 16},
    '{8'h00, 8'hc0, 8'h00, 8'hc0, 2'h2, 22'h000002, 8},
    '{8'h00, 8'hc0, 8'h00, 8'h05, 2'h2, 22'h00060c, 6192},
    '{8'h00, 8'h20, 8'h00, 8'hff, 2'h2, 22'h000001, 4},
    '{8'h00, 8'h00, 8'h40, 8'h43, 2'h2, 22'h000008, 32},
    '{8'h00, 8'h20, 8'h40, 8'h43, 2'h2, 22'h000001, 4},
    '{8'h00, 8'h40, 8'h40, 8'h02, 2'h2, 22'h000030, 192},
    '{8'h08, 8'h00, 8'h00, 8'h01, 2'h2, 22'h000004, 256},
    '{8'h00, 8'h00, 8'h00, 8'h00, 2'h3, 22'h000002, 128},
    '{8'h00, 8'h00, 8'h00, 8'h01, 2'h0, 22'h000004, 40}};
  brd_baud_rate_divider i_dut (.clk_sys(clk_sys), .nrst(nrst), .oscillator_input(osc),
    .ext_clock_in(ext), .channel_config_one(c1), .channel_config_two(c2),
    .channel_config_four(c4), .divider_low_count(low), .mode_7b(mode[1]),
    .clock_recovery_loop(mode[0]), .general_port(gp), .multidrop_mode(md),
    .transmit_request(tr), .receive_enable_req(re), .bit_tick_q(tick), .divisor_q(div),
    .synth_data_q(sd), .synth_clk_q(sc), .line_drive_en_n_q(drv_n), .line_receive_en_q(rx));
  brd_far_side i_far (.osc_out(osc), .ext_out(ext), .prog_data(sd), .prog_clk(sc),
    .prog_word(word));
  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_v(string what, logic [21:0] exp, logic [21:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_n(string what, int exp, int got);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // counts cycles up to the next tick; a lost tick ends the run
  task automatic wait_tick(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end while (tick !== 1'b1 && cyc < 20000);
    if (cyc >= 20000) begin
      miscompares++;
      final_report();
    end
  endtask
  // main sequence: reset, divider table, mid-run reset, line enables, port
  initial begin
    {nrst, c1, c2, c4, low, mode, gp, md, tr, re} = '0;
    pat = 8'ha5;
    repeat (10) @(negedge clk_sys);
    chk_v("reset divisor", 22'h000002, div);
    chk_v("reset outputs", {17'h0, 5'h02}, {17'h0, tick, sd, sc, drv_n, rx});
    nrst = 1'b1;
    foreach (rows[i]) begin
      @(negedge clk_sys);
      {c1, c2, c4, low, mode} = {rows[i].c1, rows[i].c2, rows[i].c4, rows[i].low, rows[i].mode};
      repeat (2) @(negedge clk_sys);
      chk_v("divisor", rows[i].div, div);
      wait_tick(n);
      wait_tick(n);
      chk_n("tick spacing", rows[i].per, n);
    end
    // reset mid-run with a live setting must restore the standard count zero
    @(negedge clk_sys);
    nrst = 1'b0;
    @(negedge clk_sys);
    chk_v("mid reset divisor", 22'h000002, div);
    nrst = 1'b1;
    @(negedge clk_sys);
    chk_v("divisor after reset", 22'h000004, div);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys);
      {md, tr, re} = 3'(k);
      @(negedge clk_sys);
      chk_v("driver enable", {21'h0, md ? ~tr : 1'b0}, {21'h0, drv_n});
      chk_v("receiver enable", {21'h0, md | re}, {21'h0, rx});
    end
    // upper port bits held high to show they are ignored
    for (int b = 7; b >= 0; b--) begin
      @(negedge clk_sys);
      gp = {6'h3f, 1'b0, pat[b]};
      @(negedge clk_sys);
      gp[1] = 1'b1;
      @(negedge clk_sys);
      chk_v("synth lanes", {20'h0, 1'b1, pat[b]}, {20'h0, sc, sd});
      gp[1] = 1'b0;
    end
    repeat (2) @(negedge clk_sys);
    chk_v("synth word", {14'h0, pat}, {14'h0, word});
    final_report();
  end
endmodule
`default_nettype wire
